// ---- pkg/aux_control_defs.vh ----
// constants for the auxiliary control register and dual data pointers
`ifndef AUX_CONTROL_DEFS_VH
`define AUX_CONTROL_DEFS_VH
`define AUX_CONTROL_OFS     8'hA2
`define POINTER_HIGH_OFS    8'h83
`define POINTER_LOW_OFS     8'h82
`define AUX_CONTROL_RESET   8'h00
`define POINTER_RESET       16'h0000
`define RESET_VECTOR        16'h0000
`define BIT_KEYPAD_FLAG     7
`define BIT_BROWNOUT_OFF    6
`define BIT_BROWNOUT_IRQ    5
`define BIT_LOW_POWER_PROM  4
`define BIT_SOFT_RESET      3
`define BIT_HARDWIRED_ZERO  2
`define BIT_RESERVED        1
`define BIT_POINTER_SELECT  0
`define SOFT_RESET_CYCLES   4'h4
`define OP_NONE             3'h0
`define OP_INCREMENT        3'h1
`define OP_LOAD_IMMEDIATE   3'h2
`define UNMAPPED_READ       32'h0000_0000
`endif

// ---- core/pointer_word.v ----
// one sixteen-bit data pointer with increment, load and byte writes
`timescale 1ns/1ps
`default_nettype none
`include "aux_control_defs.vh"
module pointer_word (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire        chip_rst,
  input  wire        sel,
  input  wire [2:0]  op,
  input  wire [15:0] load_value,
  input  wire        wr_high,
  input  wire        wr_low,
  input  wire [7:0]  wr_byte,
  output reg  [15:0] value_r
);
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      value_r <= `POINTER_RESET;
    end else if (chip_rst) begin
      value_r <= `POINTER_RESET;
    end else if (sel) begin
      if (op == `OP_INCREMENT) begin
        value_r <= value_r + 16'h0001;
      end else if (op == `OP_LOAD_IMMEDIATE) begin
        value_r <= load_value;
      end else begin
        if (wr_high) value_r[15:8] <= wr_byte;
        if (wr_low)  value_r[7:0]  <= wr_byte;
      end
    end
  end
endmodule // pointer_word
`default_nettype wire

// ---- core/soft_reset_pulse.v ----
// stretches a software reset request into a chip reset pulse
`timescale 1ns/1ps
`default_nettype none
`include "aux_control_defs.vh"
module soft_reset_pulse (
  input  wire clock,
  input  wire sys_rst,
  input  wire trigger,
  output wire chip_rst
);
  reg [3:0] count_r;
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      count_r <= 4'h0;
    end else if (trigger) begin
      count_r <= `SOFT_RESET_CYCLES;
    end else if (count_r != 4'h0) begin
      count_r <= count_r - 4'h1;
    end
  end
  assign chip_rst = (count_r != 4'h0);
endmodule // soft_reset_pulse
`default_nettype wire

// ---- core/aux_control_dual_pointer.v ----
// auxiliary control register, software reset and dual data pointers
`timescale 1ns/1ps
`default_nettype none
`include "aux_control_defs.vh"
module aux_control_dual_pointer (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire        ext_rst,
  input  wire        watchdog_rst,
  input  wire        keypad_event,
  input  wire [2:0]  pointer_op,
  input  wire [15:0] pointer_load_value,
  input  wire [7:0]  accumulator,
  output reg  [15:0] indexed_address,
  output reg  [15:0] data_memory_address,
  output wire        data_memory_internal_only,
  output wire        chip_rst,
  output wire [15:0] restart_address,
  output wire        brownout_enable,
  output wire        brownout_irq_mode,
  output wire        low_power_prom,
  output wire        pointer_select
);
  reg         ack_r;
  reg  [7:0]  aux_r;
  reg  [7:0]  aux_nxt;
  reg         ext_meta_r;
  reg         ext_sync_r;
  reg         key_meta_r;
  reg         key_sync_r;
  reg         key_prev_r;
  wire        soft_chip_rst;
  wire        soft_trigger;
  wire        any_rst;
  wire [15:0] ptr0;
  wire [15:0] ptr1;
  wire [15:0] cur_ptr;
  wire        wr_req;
  wire        hit_aux;
  wire        hit_high;
  wire        hit_low;
  wire        key_rise;
  wire [7:0]  wbyte;

  // one wait cycle per access, answer on second edge
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wr_req   = avs_write & ack_r & avs_byteenable[0];
  assign wbyte    = avs_writedata[7:0];
  assign hit_aux  = (avs_address == `AUX_CONTROL_OFS);
  assign hit_high = (avs_address == `POINTER_HIGH_OFS);
  assign hit_low  = (avs_address == `POINTER_LOW_OFS);

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
    end
  end

  // ext_rst and keypad_event pass two flip-flops; watchdog_rst goes to the chip reset unsynchronised
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ext_meta_r <= 1'b0;
      ext_sync_r <= 1'b0;
      key_meta_r <= 1'b0;
      key_sync_r <= 1'b0;
      key_prev_r <= 1'b0;
    end else begin
      ext_meta_r <= ext_rst;
      ext_sync_r <= ext_meta_r;
      key_meta_r <= keypad_event;
      key_sync_r <= key_meta_r;
      key_prev_r <= key_sync_r;
    end
  end
  assign key_rise = key_sync_r & ~key_prev_r;

  assign soft_trigger = wr_req & hit_aux & wbyte[`BIT_SOFT_RESET];

  soft_reset_pulse u_soft_reset (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .trigger  (soft_trigger),
    .chip_rst (soft_chip_rst)
  );

  // software, external and watchdog resets merge into one chip reset
  assign any_rst  = soft_chip_rst | ext_sync_r | watchdog_rst;
  assign chip_rst = any_rst;
  assign restart_address = `RESET_VECTOR;

  always @* begin
    aux_nxt = aux_r;
    if (wr_req & hit_aux) begin
      aux_nxt = wbyte;
      aux_nxt[`BIT_KEYPAD_FLAG] = wbyte[`BIT_KEYPAD_FLAG] & aux_r[`BIT_KEYPAD_FLAG];
    end
    if (key_rise) begin
      aux_nxt[`BIT_KEYPAD_FLAG] = 1'b1;
    end
    aux_nxt[`BIT_SOFT_RESET]     = 1'b0;
    aux_nxt[`BIT_HARDWIRED_ZERO] = 1'b0;
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      aux_r <= `AUX_CONTROL_RESET;
    end else if (any_rst) begin
      aux_r <= `AUX_CONTROL_RESET;
    end else begin
      aux_r <= aux_nxt;
    end
  end

  assign pointer_select     = aux_r[`BIT_POINTER_SELECT];
  assign brownout_enable    = ~aux_r[`BIT_BROWNOUT_OFF];
  assign brownout_irq_mode  = aux_r[`BIT_BROWNOUT_IRQ];
  assign low_power_prom     = aux_r[`BIT_LOW_POWER_PROM];

  pointer_word u_ptr0 (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .chip_rst   (any_rst),
    .sel        (~pointer_select),
    .op         (pointer_op),
    .load_value (pointer_load_value),
    .wr_high    (wr_req & hit_high),
    .wr_low     (wr_req & hit_low),
    .wr_byte    (wbyte),
    .value_r    (ptr0)
  );

  pointer_word u_ptr1 (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .chip_rst   (any_rst),
    .sel        (pointer_select),
    .op         (pointer_op),
    .load_value (pointer_load_value),
    .wr_high    (wr_req & hit_high),
    .wr_low     (wr_req & hit_low),
    .wr_byte    (wbyte),
    .value_r    (ptr1)
  );

  assign cur_ptr = pointer_select ? ptr1 : ptr0;
  assign data_memory_internal_only = 1'b1;

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      indexed_address     <= 16'h0000;
      data_memory_address <= 16'h0000;
    end else begin
      indexed_address     <= cur_ptr + {8'h00, accumulator};
      data_memory_address <= cur_ptr;
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~ack_r) begin
      if (hit_aux) begin
        avs_readdata <= {24'h00_0000, aux_r};
      end else if (hit_high) begin
        avs_readdata <= {24'h00_0000, cur_ptr[15:8]};
      end else if (hit_low) begin
        avs_readdata <= {24'h00_0000, cur_ptr[7:0]};
      end else begin
        avs_readdata <= `UNMAPPED_READ;
      end
    end
  end
endmodule // aux_control_dual_pointer
`default_nettype wire

// ---- sim/aux_control_props.sv ----
// assertion checker for the auxiliary control register block
`timescale 1ns/1ps
`default_nettype none
module aux_control_props (
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        watchdog_rst,
  input wire logic [2:0]  pointer_op,
  input wire logic [7:0]  accumulator,
  input wire logic [15:0] indexed_address,
  input wire logic [15:0] data_memory_address,
  input wire logic        data_memory_internal_only,
  input wire logic        chip_rst,
  input wire logic [15:0] restart_address,
  input wire logic        brownout_enable,
  input wire logic        pointer_select
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire wr_aux = avs_write && !avs_waitrequest && avs_address == 8'ha2 && avs_byteenable[0];
  wire rd_ack = avs_read && !avs_waitrequest;
  wire bo_req = avs_writedata[6];
  a_soft_reset_len: assert property (wr_aux && avs_writedata[3] |=> chip_rst [*4])
    else $error("soft reset pulse wrong");
  a_restart_vector: assert property (restart_address == 16'h0000)
    else $error("restart address not zero");
  a_watchdog_reset: assert property (watchdog_rst |-> chip_rst)
    else $error("watchdog reset not passed on");
  a_reset_clears: assert property (chip_rst |=> !pointer_select && brownout_enable)
    else $error("register not cleared by reset");
  a_bit2_zero: assert property (rd_ack && avs_address == 8'ha2 |-> avs_readdata[3:2] == 2'b00)
    else $error("bit 2 or 3 reads one");
  a_increment_one: assert property ((pointer_op == 3'h1 && !chip_rst ##1 pointer_op == 3'h0
    && !chip_rst && $stable(pointer_select)) |=> data_memory_address == $past(data_memory_address) + 16'h0001)
    else $error("increment not by one");
  a_indexed_sum: assert property (!$past(sys_rst) |->
    indexed_address == data_memory_address + {8'h00, $past(accumulator)})
    else $error("indexed address wrong");
  a_internal_only: assert property (data_memory_internal_only)
    else $error("external data bus claimed");
  a_brownout_bit: assert property (wr_aux && !avs_writedata[3] && !chip_rst |=>
    brownout_enable == !$past(bo_req))
    else $error("brownout enable wrong");
  cover property (wr_aux && avs_writedata[3]);
  cover property (pointer_op == 3'h1);
  cover property (watchdog_rst);
endmodule // aux_control_props
bind aux_control_dual_pointer aux_control_props u_props (.*);
`default_nettype wire

// ---- sim/aux_control_dual_pointer_tb.sv ----
// self-checking bench for the auxiliary control register block
`timescale 1ns/1ps
`default_nettype none
module aux_control_dual_pointer_tb;
  logic        clock = 0, sys_rst = 1, avs_read = 0, avs_write = 0;
  logic        ext_rst = 0, watchdog_rst = 0, keypad_event = 0;
  logic [7:0]  avs_address = 0, accumulator = 0, k;
  logic [31:0] avs_writedata = 0, avs_readdata, exp_q[$];
  logic [3:0]  avs_byteenable = 4'hf;
  logic [2:0]  pointer_op = 0;
  logic [15:0] pointer_load_value = 0, a, b, c, s = 16'h004e;
  wire         avs_waitrequest, data_memory_internal_only, chip_rst, brownout_enable;
  wire         brownout_irq_mode, low_power_prom, pointer_select;
  wire  [15:0] indexed_address, data_memory_address, restart_address;
  int          errors = 0, tests_run = 0, cyc = 0;
  aux_control_dual_pointer dut (.*);
  always #5 clock = ~clock;
  function automatic logic [15:0] rnd();
    s ^= s << 7;
    s ^= s >> 9;
    s ^= s << 8;
    return s;
  endfunction
  task check(input string n, input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s exp %h got %h", n, exp, got);
    end
  endtask
  task give_verdict();
    $display("counts: %0d checks, %0d mismatches", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clock) begin
    if (avs_read && !avs_waitrequest) check("readdata", avs_readdata, exp_q.pop_front());
    cyc++;
    if (cyc == 5000) begin
      errors++;
      give_verdict();
    end
  end
  task bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= ad;
    avs_writedata <= d;
    do @(posedge clock); while (avs_waitrequest);
    avs_read <= 0;
    avs_write <= 0;
    @(posedge clock);
  endtask
  task wr(input logic [7:0] ad, input logic [31:0] d); bus(1, ad, d); endtask
  task rd(input logic [7:0] ad, input logic [31:0] e);
    exp_q.push_back(e);
    bus(0, ad, 0);
  endtask
  task wrp(input logic [15:0] v); wr(8'h82, v[7:0]); wr(8'h83, v[15:8]); endtask
  task rdp(input logic [15:0] v); rd(8'h82, v[7:0]); rd(8'h83, v[15:8]); endtask
  task op(input logic [2:0] o, input logic [15:0] v);
    pointer_op <= o;
    pointer_load_value <= v;
    @(posedge clock);
    pointer_op <= 0;
    @(posedge clock);
  endtask
  task pulse_rst(input bit wd);
    if (wd) watchdog_rst <= 1;
    else ext_rst <= 1;
    repeat (3) @(posedge clock);
    watchdog_rst <= 0;
    ext_rst <= 0;
    repeat (8) @(posedge clock);
  endtask
  initial begin
    repeat (10) @(posedge clock);
    sys_rst <= 0;
    @(posedge clock);
    rd(8'ha2, 0);
    check("brownout_enable", brownout_enable, 1);
    a = rnd();
    b = rnd();
    c = rnd() | 16'h00ff;
    wrp(a);
    wr(8'ha2, 1);
    wrp(b);
    rdp(b);
    wr(8'ha2, 0);
    rdp(a);
    op(3'h2, c);
    op(3'h1, 0);
    rdp(c + 16'h0001);
    wr(8'ha2, 1);
    rdp(b);
    k = rnd();
    accumulator <= k;
    c = b + k;
    repeat (2) @(posedge clock);
    check("indexed_address", indexed_address, c);
    $display("test pointers done");
    wr(8'ha2, 8'h75);
    rd(8'ha2, 8'h71);
    check("brownout_enable", brownout_enable, 0);
    check("brownout_irq_mode", brownout_irq_mode, 1);
    check("low_power_prom", low_power_prom, 1);
    check("pointer_select", pointer_select, 1);
    wr(8'ha2, 8'h72);
    rd(8'ha2, 8'h72);
    keypad_event <= 1;
    repeat (5) @(posedge clock);
    keypad_event <= 0;
    rd(8'ha2, 8'hf2);
    wr(8'ha2, 8'h72);
    avs_byteenable <= 0;
    wr(8'ha2, 8'h01);
    avs_byteenable <= 4'hf;
    rd(8'ha2, 8'h72);
    rd(8'h10, 0);
    $display("test control bits done");
    wr(8'ha2, 8'h09);
    repeat (6) @(posedge clock);
    rd(8'ha2, 0);
    rdp(0);
    wrp(a);
    pulse_rst(1);
    rdp(0);
    wrp(a);
    pulse_rst(0);
    rdp(0);
    $display("test resets done");
    give_verdict();
  end
endmodule // aux_control_dual_pointer_tb
`default_nettype wire
